// ---- pkg/qpmrd_regs.vh ----
// register map, field positions and timing constants of the management register block
`ifndef QPMRD_REGS_VH
`define QPMRD_REGS_VH

// register addresses
`define REG_CTRL        5'h00
`define REG_STAT        5'h01
`define REG_ID_HIGH     5'h02
`define REG_ID_LOW      5'h03
`define REG_IRQ         5'h10
`define REG_SUMMARY     5'h11

// frame fields
`define OP_READ         2'b10
`define OP_WRITE        2'b01
`define HEAD_LAST       5'd12
`define TAIL_TA2        5'd1
`define TAIL_D15        5'd2
`define TAIL_LAST       5'd17

// autoneg control fields
`define CTRL_SRST       15
`define CTRL_LOOP       14
`define CTRL_NEGOTIATION_ENABLE    12
`define CTRL_PORT_POWER_DOWN     11
`define CTRL_RESTART    9
`define CTRL_DUPLEX     8
`define CTRL_COL_TEST   7
`define CTRL_DEFAULT    16'h1000
`define CTRL_WMASK      16'hDB80
`define CTRL_SRST_BIT   16'h8000

// autoneg status fields
`define STAT_FIXED      16'h1849
`define STAT_ANEG_DONE  5
`define STAT_LINK       2
`define STAT_JABBER     1

// interrupt register layout
`define IRQ_EN_HI       15
`define IRQ_EN_LO       8

// strap capture delay after reset release
`define STRAP_WAIT      2'd2

// soft port reset duration
`define SRST_NS         10000
`define CLK_PERIOD_NS   10

`endif

// ---- src/qpmrd_top.v ----
// management register decode of a four-channel phy, reached over the serial management link
//
// Contract
// - answer frames only when phy address bits 4..2 equal strapped chip address.
// - low two phy address bits select channel 0 to 3 for per-port registers.
// - set per-port status bits on link, duplex or negotiation changes and on jabber onset.
// - interrupt status and enable bits share register 16.
// - status bits update on events regardless of their enable bits.
// - open-drain interrupt output active when any enabled status bit is set.
// - change status bits 3..0 clear when read over the management link; jabber bits 7..4 do not.
// - jabber status bit clears itself when the port leaves jabber.
// - registers 2, 3, 16, 17 ignore the channel bits of the address.
// - per-port registers exist per channel; only the matching channel is accessed.
// - control bit 15 resets port control to defaults, self-clears after 10 us.
// - control bit 14 loops port transmit data back to receive data.
// - control bit 11 resets negotiation and stops link state machine and pulses.
// - control bit 9 restarts negotiation, self-clears when negotiation completes.
// - control bits 13 and 10 always read zero.
// - strap values are captured at reset release; strap pins undriven during reset.
// - frames: start 01, opcode 10 read or 01 write, addresses, turnaround, data.
`timescale 1ns/1ps
`include "qpmrd_regs.vh"

module qpmrd_top #(
    parameter [15:0] ID_HIGH = 16'hA5A5,           // arbitrary identity value
    parameter [15:0] ID_LOW  = 16'h5A50            // arbitrary identity value
) (
    input  wire        CLK_I,                      // system clock, 100 MHz
    input  wire        RESET_I,                    // async reset, active high
    input  wire        MDC_I,                      // management clock pin
    input  wire        MDIO_I,                     // management data pin level
    output reg         MDIO_O,                     // management data drive value
    output reg         MDIO_OE_O,                  // management data drive enable
    input  wire        SLOTTED_RX_DATA_PIN_I,      // chip address strap bit 4
    input  wire        SLOTTED_RX_VALID_PIN_I,     // chip address strap bit 3
    input  wire        SLOTTED_COLLISION_PIN_I,    // chip address strap bit 2
    output reg         SLOTTED_PINS_OE_O,          // strap pins may be driven
    input  wire [3:0]  LINK_UP_I,                  // per-port link status
    input  wire [3:0]  FULL_DUPLEX_I,              // per-port duplex mode
    input  wire [3:0]  NEGOTIATION_DONE_I,         // per-port negotiation complete
    input  wire [3:0]  JABBER_I,                   // per-port jabber state
    output wire        STATUS_CHANGE_IRQ_N_O,      // interrupt drive value, always low
    output reg         STATUS_CHANGE_IRQ_N_OE_O,   // interrupt pulled low when high
    output wire [3:0]  SOFT_PORT_RESET_O,          // per-port soft reset in progress
    output wire [3:0]  LOOPBACK_O,                 // per-port loopback
    output wire [3:0]  NEGOTIATION_ENABLE_O,       // per-port negotiation enable
    output wire [3:0]  PORT_POWER_DOWN_O,          // per-port negotiation halt
    output wire [3:0]  NEGOTIATION_RESTART_O,      // per-port restart request
    output wire [3:0]  DUPLEX_MODE_O,              // per-port forced duplex
    output wire [3:0]  COLLISION_TEST_O            // per-port collision test
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_HEAD = 2'b01;
    localparam [1:0] ST_TAIL = 2'b10;
    localparam [31:0] SRST_FULL  = (`SRST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [9:0] SRST_CYCLES = SRST_FULL[9:0];

    reg         mdc_s1;
    reg         mdc_s2;
    reg         mdc_s3;
    reg         mdio_s1;
    reg         mdio_s2;
    reg  [2:0]  strap_s1;
    reg  [2:0]  strap_s2;
    reg  [2:0]  strap;
    reg  [1:0]  cap_cnt;
    reg  [1:0]  state;
    reg  [4:0]  cnt;
    reg  [11:0] head;
    reg  [4:0]  regad;
    reg  [1:0]  chan;
    reg         is_rd;
    reg         hit;
    reg  [15:0] sh;
    reg         wr_stb;
    reg  [15:0] wr_data;
    reg  [7:0]  irq_en;
    reg  [15:0] rdata;
    wire [7:0]  irq_st;
    wire [63:0] ctrl_all;
    wire        mdc_rise;
    wire [12:0] next_head;
    wire        rd_stb;
    wire        rd_irq;

    // synchronisers for the pins
    always @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mdc_s1   <= 1'b0;
            mdc_s2   <= 1'b0;
            mdc_s3   <= 1'b0;
            mdio_s1  <= 1'b1;
            mdio_s2  <= 1'b1;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
        end else begin
            mdc_s1   <= MDC_I;
            mdc_s2   <= mdc_s1;
            mdc_s3   <= mdc_s2;
            mdio_s1  <= MDIO_I;
            mdio_s2  <= mdio_s1;
            strap_s1 <= {SLOTTED_RX_DATA_PIN_I, SLOTTED_RX_VALID_PIN_I, SLOTTED_COLLISION_PIN_I};
            strap_s2 <= strap_s1;
        end
    end

    assign mdc_rise = mdc_s2 & ~mdc_s3;

    // strap capture once the synchronisers hold post-release samples
    always @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cap_cnt           <= 2'h0;
            strap             <= 3'h0;
            SLOTTED_PINS_OE_O <= 1'b0;
        end else if (cap_cnt != `STRAP_WAIT) begin
            cap_cnt <= cap_cnt + 2'h1;
        end else if (!SLOTTED_PINS_OE_O) begin
            strap             <= strap_s2;
            SLOTTED_PINS_OE_O <= 1'b1;
        end
    end

    assign next_head = {head, mdio_s2};
    assign rd_stb    = mdc_rise && (state == ST_TAIL) && (cnt == `TAIL_TA2) && is_rd && hit;
    assign rd_irq    = rd_stb && (regad == `REG_IRQ);

    // management frame engine, sampled on management clock rising edges
    always @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state     <= ST_IDLE;
            cnt       <= 5'h00;
            head      <= 12'h000;
            regad     <= 5'h00;
            chan      <= 2'h0;
            is_rd     <= 1'b0;
            hit       <= 1'b0;
            sh        <= 16'h0000;
            MDIO_O    <= 1'b0;
            MDIO_OE_O <= 1'b0;
            wr_stb    <= 1'b0;
            wr_data   <= 16'h0000;
        end else begin
            wr_stb <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    ST_IDLE: begin
                        if (!mdio_s2) begin
                            state <= ST_HEAD;
                            cnt   <= 5'h00;
                        end
                    end
                    ST_HEAD: begin
                        head <= next_head[11:0];
                        cnt  <= cnt + 5'h01;
                        if (cnt == `HEAD_LAST) begin
                            cnt   <= 5'h00;
                            regad <= next_head[4:0];
                            chan  <= next_head[6:5];
                            is_rd <= (next_head[11:10] == `OP_READ);
                            hit   <= (next_head[9:7] == strap);
                            if (!next_head[12] || ((next_head[11:10] != `OP_READ) &&
                                                   (next_head[11:10] != `OP_WRITE))) begin
                                state <= ST_IDLE;
                            end else begin
                                state <= ST_TAIL;
                            end
                        end
                    end
                    ST_TAIL: begin
                        cnt <= cnt + 5'h01;
                        if (is_rd && hit) begin
                            if (cnt == 5'h00) begin
                                MDIO_OE_O <= 1'b1;
                                MDIO_O    <= 1'b0;
                            end else if (cnt == `TAIL_TA2) begin
                                MDIO_O <= rdata[15];
                                sh     <= {rdata[14:0], 1'b0};
                            end else if (cnt != `TAIL_LAST) begin
                                MDIO_O <= sh[15];
                                sh     <= {sh[14:0], 1'b0};
                            end
                        end else if (!is_rd && (cnt >= `TAIL_D15)) begin
                            sh <= {sh[14:0], mdio_s2};
                        end
                        if (cnt == `TAIL_LAST) begin
                            state     <= ST_IDLE;
                            MDIO_OE_O <= 1'b0;
                            MDIO_O    <= 1'b0;
                            wr_stb    <= !is_rd && hit;
                            wr_data   <= {sh[14:0], mdio_s2};
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // read data mux
    always @* begin
        rdata = 16'h0000;
        case (regad)
            `REG_CTRL:    rdata = ctrl_all[{chan, 4'h0} +: 16];
            `REG_STAT: begin
                rdata = `STAT_FIXED;
                rdata[`STAT_ANEG_DONE] = NEGOTIATION_DONE_I[chan];
                rdata[`STAT_LINK]      = LINK_UP_I[chan];
                rdata[`STAT_JABBER]    = JABBER_I[chan];
            end
            `REG_ID_HIGH: rdata = ID_HIGH;
            `REG_ID_LOW:  rdata = ID_LOW;
            `REG_IRQ:     rdata = {irq_en, irq_st};
            `REG_SUMMARY: rdata = {12'h000, LINK_UP_I};
            default:      rdata = 16'h0000;
        endcase
    end

    // interrupt enables and the open-drain output
    always @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_en                   <= 8'h00;
            STATUS_CHANGE_IRQ_N_OE_O <= 1'b0;
        end else begin
            if (wr_stb && (regad == `REG_IRQ)) begin
                irq_en <= wr_data[`IRQ_EN_HI:`IRQ_EN_LO];
            end
            STATUS_CHANGE_IRQ_N_OE_O <= |(irq_st & irq_en);
        end
    end

    assign STATUS_CHANGE_IRQ_N_O = 1'b0;

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            reg  [15:0] ctrl;
            reg  [9:0]  srst_cnt;
            reg         lk_q;
            reg         dx_q;
            reg         an_q;
            reg         jb_q;
            reg         chg_st;
            reg         jab_st;
            wire        wr_me     = wr_stb && (regad == `REG_CTRL) && (chan == p);
            wire        done_rise = NEGOTIATION_DONE_I[p] & ~an_q;
            wire        chg       = (LINK_UP_I[p] ^ lk_q) | (FULL_DUPLEX_I[p] ^ dx_q) |
                                    (NEGOTIATION_DONE_I[p] ^ an_q);

            always @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    lk_q   <= 1'b0;
                    dx_q   <= 1'b0;
                    an_q   <= 1'b0;
                    jb_q   <= 1'b0;
                    chg_st <= 1'b0;
                    jab_st <= 1'b0;
                end else begin
                    lk_q   <= LINK_UP_I[p];
                    dx_q   <= FULL_DUPLEX_I[p];
                    an_q   <= NEGOTIATION_DONE_I[p];
                    jb_q   <= JABBER_I[p];
                    chg_st <= chg | (chg_st & ~rd_irq);
                    jab_st <= (JABBER_I[p] & ~jb_q) | (jab_st & JABBER_I[p]);
                end
            end

            always @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    ctrl     <= `CTRL_DEFAULT;
                    srst_cnt <= 10'h000;
                end else if (wr_me && wr_data[`CTRL_SRST]) begin
                    ctrl     <= `CTRL_DEFAULT | `CTRL_SRST_BIT;
                    srst_cnt <= SRST_CYCLES;
                end else if (wr_me) begin
                    ctrl <= (wr_data & `CTRL_WMASK) | (ctrl & `CTRL_SRST_BIT);
                    // a pending restart is only cleared by negotiation completing or by a soft reset
                    if (ctrl[`CTRL_RESTART]) begin
                        ctrl[`CTRL_RESTART] <= 1'b1;
                    end
                end else begin
                    if (srst_cnt != 10'h000) begin
                        srst_cnt <= srst_cnt - 10'h001;
                        if (srst_cnt == 10'h001) begin
                            ctrl[`CTRL_SRST] <= 1'b0;
                        end
                    end
                    if (done_rise) begin
                        ctrl[`CTRL_RESTART] <= 1'b0;
                    end
                end
            end

            assign ctrl_all[p*16 +: 16]   = ctrl;
            assign irq_st[p]              = chg_st;
            assign irq_st[p+4]            = jab_st;
            assign SOFT_PORT_RESET_O[p]     = ctrl[`CTRL_SRST];
            assign LOOPBACK_O[p]            = ctrl[`CTRL_LOOP];
            assign NEGOTIATION_ENABLE_O[p]  = ctrl[`CTRL_NEGOTIATION_ENABLE];
            assign PORT_POWER_DOWN_O[p]     = ctrl[`CTRL_PORT_POWER_DOWN];
            assign NEGOTIATION_RESTART_O[p] = ctrl[`CTRL_RESTART];
            assign DUPLEX_MODE_O[p]         = ctrl[`CTRL_DUPLEX];
            assign COLLISION_TEST_O[p]      = ctrl[`CTRL_COL_TEST];
        end
    endgenerate

endmodule // qpmrd_top

// ---- tb/qpmrd_props.sv ----
// assertion checker for the management register decode block
`timescale 1ns/1ps
module qpmrd_props (
    input wire       CLK_I,                  // clock
    input wire       RESET_I,                // reset
    input wire       MDC_I,                  // link clock
    input wire       MDIO_O,                 // data drive value
    input wire       MDIO_OE_O,              // data drive enable
    input wire       SLOTTED_PINS_OE_O,      // strap pins released
    input wire [3:0] NEGOTIATION_DONE_I,     // negotiation complete
    input wire       STATUS_CHANGE_IRQ_N_O,  // irq drive value
    input wire [3:0] SOFT_PORT_RESET_O,      // soft reset
    input wire [3:0] LOOPBACK_O,             // loopback
    input wire [3:0] NEGOTIATION_ENABLE_O,   // negotiation enable
    input wire [3:0] NEGOTIATION_RESTART_O   // restart request
);
    reg        mdc_q;
    reg [4:0]  n_rise;
    reg [10:0] srst_len;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // link clock rises while the data line is driven, and soft reset length
    always @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mdc_q    <= 1'b0;
            n_rise   <= 5'h00;
            srst_len <= 11'h000;
        end else begin
            mdc_q    <= MDC_I;
            n_rise   <= MDIO_OE_O ? n_rise + {4'h0, MDC_I & ~mdc_q} : 5'h00;
            srst_len <= SOFT_PORT_RESET_O[1] ? srst_len + 11'h001 : 11'h000;
        end
    end
    property p_irq_level; STATUS_CHANGE_IRQ_N_O == 1'b0; endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq drive value not low");
    property p_strap_hold; $fell(RESET_I) |-> !SLOTTED_PINS_OE_O [*2]; endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap pins driven too early");
    property p_strap_keep; SLOTTED_PINS_OE_O |=> SLOTTED_PINS_OE_O; endproperty
    a_strap_keep: assert property (p_strap_keep) else $error("strap enable dropped");
    property p_ta_zero; $rose(MDIO_OE_O) |-> !MDIO_O; endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("turnaround bit not zero");
    property p_read_len; $fell(MDIO_OE_O) |-> n_rise == 5'd17; endproperty
    a_read_len: assert property (p_read_len) else $error("read drive length wrong");
    property p_srst_dflt;
        $rose(SOFT_PORT_RESET_O[1]) |-> NEGOTIATION_ENABLE_O[1] && !LOOPBACK_O[1] && !NEGOTIATION_RESTART_O[1];
    endproperty
    a_srst_dflt: assert property (p_srst_dflt) else $error("soft reset left control bits");
    property p_srst_len; $fell(SOFT_PORT_RESET_O[1]) |-> srst_len >= 11'd999 && srst_len <= 11'd1001; endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
    property p_restart_clr;
        $fell(NEGOTIATION_RESTART_O[2]) |->
            ($past(NEGOTIATION_DONE_I[2]) && !$past(NEGOTIATION_DONE_I[2], 2)) || SOFT_PORT_RESET_O[2];
    endproperty
    a_restart_clr: assert property (p_restart_clr) else $error("restart cleared without completion");
endmodule // qpmrd_props
bind qpmrd_top qpmrd_props i_props (.CLK_I(CLK_I), .RESET_I(RESET_I), .MDC_I(MDC_I), .MDIO_O(MDIO_O),
    .MDIO_OE_O(MDIO_OE_O), .SLOTTED_PINS_OE_O(SLOTTED_PINS_OE_O), .NEGOTIATION_DONE_I(NEGOTIATION_DONE_I),
    .STATUS_CHANGE_IRQ_N_O(STATUS_CHANGE_IRQ_N_O), .SOFT_PORT_RESET_O(SOFT_PORT_RESET_O),
    .LOOPBACK_O(LOOPBACK_O), .NEGOTIATION_ENABLE_O(NEGOTIATION_ENABLE_O),
    .NEGOTIATION_RESTART_O(NEGOTIATION_RESTART_O));

// ---- tb/qpmrd_mgmt_master.sv ----
// station management controller model sending frames on the serial link
`timescale 1ns/1ps
module qpmrd_mgmt_master (
    input  wire mdio_i,     // resolved data line
    output reg  mdc_o,      // link clock, still between frames
    output reg  mdio_o,     // drive value
    output reg  mdio_oe_o   // drive enable
);
    integer    i;
    reg [31:0] frame;
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end
    // data changes while the clock is low, read bits taken at the rise
    task xfer(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] wd, output [15:0] rd);
        begin
            frame = {2'b01, op, phy, ra, 2'b10, wd};
            rd = 16'h0000;
            for (i = 31; i >= 0; i = i - 1) begin
                mdio_oe_o = (op == 2'b01) || (i > 17);
                mdio_o = frame[i];
                #40 mdc_o = 1'b1;
                if (i < 16) rd[i] = mdio_i;
                #40 mdc_o = 1'b0;
            end
            mdio_oe_o = 1'b0;
        end
    endtask
endmodule // qpmrd_mgmt_master

// ---- tb/tb_top.sv ----
// self-checking bench for the management register decode block
`timescale 1ns/1ps
`include "qpmrd_regs.vh"
module tb_top;
    localparam [2:0]  CHIP = 3'b101;
    localparam [15:0] ID_H = 16'h1234;   // arbitrary identity value
    localparam [15:0] ID_L = 16'h4321;   // arbitrary identity value
    reg        clk, rst;
    reg [3:0]  link, dplx, done, jab;
    wire       mdc, m_o, m_oe, d_o, d_oe, irq_oe;
    wire [3:0] srst, loop, aneg, pd, rstrt, fdx, ctst;
    wire       mdio = d_oe ? d_o : (m_oe ? m_o : 1'b1);
    integer    n_errors, check_count, k;
    reg [15:0] rd;
    qpmrd_top #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) i_dut (.CLK_I(clk), .RESET_I(rst), .MDC_I(mdc), .MDIO_I(mdio),
        .MDIO_O(d_o), .MDIO_OE_O(d_oe), .SLOTTED_RX_DATA_PIN_I(1'b1), .SLOTTED_RX_VALID_PIN_I(1'b0),
        .SLOTTED_COLLISION_PIN_I(1'b1), .SLOTTED_PINS_OE_O(), .LINK_UP_I(link), .FULL_DUPLEX_I(dplx),
        .NEGOTIATION_DONE_I(done), .JABBER_I(jab), .STATUS_CHANGE_IRQ_N_O(), .STATUS_CHANGE_IRQ_N_OE_O(irq_oe),
        .SOFT_PORT_RESET_O(srst), .LOOPBACK_O(loop), .NEGOTIATION_ENABLE_O(aneg), .PORT_POWER_DOWN_O(pd),
        .NEGOTIATION_RESTART_O(rstrt), .DUPLEX_MODE_O(fdx), .COLLISION_TEST_O(ctst));
    qpmrd_mgmt_master i_master (.mdio_i(mdio), .mdc_o(mdc), .mdio_o(m_o), .mdio_oe_o(m_oe));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [4:0] phy, input [4:0] ra, input [15:0] exp);
        begin
            @(posedge clk) @(negedge clk);
            i_master.xfer(`OP_READ, phy, ra, 16'h0000, rd);
            chk(rd, exp);
        end
    endtask
    task wr(input [4:0] phy, input [4:0] ra, input [15:0] wd);
        begin
            @(posedge clk) @(negedge clk);
            i_master.xfer(`OP_WRITE, phy, ra, wd, rd);
            repeat (4) @(negedge clk);
        end
    endtask
    task complete_run;
        begin
            if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task t_reset_map;
        begin
            for (k = 0; k < 4; k = k + 1) rdc({CHIP, k[1:0]}, `REG_CTRL, `CTRL_DEFAULT);
            link[1] = 1'b1;
            rdc({CHIP, 2'd1}, `REG_STAT, 16'h184D);
            rdc({CHIP, 2'd0}, `REG_STAT, 16'h1849);
            rdc({CHIP, 2'd3}, `REG_ID_HIGH, ID_H);
            rdc({CHIP, 2'd2}, `REG_ID_LOW, ID_L);
            rdc({CHIP, 2'd0}, 5'h08, 16'h0000);
        end
    endtask
    task t_chip_sel;
        begin
            wr({3'b001, 2'd0}, `REG_CTRL, 16'h4000);
            chk({12'h000, loop}, 16'h0000);
            rdc({3'b001, 2'd0}, `REG_CTRL, 16'hFFFF);
            wr({CHIP, 2'd0}, 5'h15, 16'hFFFF);
            rdc({CHIP, 2'd0}, `REG_CTRL, `CTRL_DEFAULT);
        end
    endtask
    task t_ctrl;
        begin
            wr({CHIP, 2'd2}, `REG_CTRL, 16'h7F80);
            chk({12'h000, loop}, 16'h0004);
            chk({12'h000, pd}, 16'h0004);
            chk({12'h000, rstrt}, 16'h0004);
            chk({4'h0, fdx, ctst, aneg}, 16'h044F);
            rdc({CHIP, 2'd2}, `REG_CTRL, 16'h5B80);
            wr({CHIP, 2'd2}, `REG_CTRL, 16'h5980);
            rdc({CHIP, 2'd2}, `REG_CTRL, 16'h5B80);
            rdc({CHIP, 2'd1}, `REG_CTRL, `CTRL_DEFAULT);
            done[2] = 1'b1;
            repeat (4) @(negedge clk);
            chk({12'h000, rstrt}, 16'h0000);
            done[2] = 1'b0;
        end
    endtask
    task t_srst;
        begin
            wr({CHIP, 2'd1}, `REG_CTRL, 16'h4000);
            wr({CHIP, 2'd1}, `REG_CTRL, `CTRL_SRST_BIT);
            chk({12'h000, srst}, 16'h0002);
            chk({12'h000, loop}, 16'h0004);
            for (k = 0; k < 1200 && srst[1] === 1'b1; k = k + 1) @(negedge clk);
            chk({15'h0000, k >= 990 && k <= 1000}, 16'h0001);
            rdc({CHIP, 2'd1}, `REG_CTRL, `CTRL_DEFAULT);
        end
    endtask
    task t_irq;
        begin
            chk({15'h0000, irq_oe}, 16'h0000);
            rdc({CHIP, 2'd3}, `REG_IRQ, 16'h0006);
            rdc({CHIP, 2'd0}, `REG_IRQ, 16'h0000);
            wr({CHIP, 2'd1}, `REG_IRQ, 16'h08FF);
            dplx[3] = 1'b1;
            repeat (4) @(negedge clk);
            chk({15'h0000, irq_oe}, 16'h0001);
            rdc({CHIP, 2'd2}, `REG_IRQ, 16'h0808);
            chk({15'h0000, irq_oe}, 16'h0000);
            jab[0] = 1'b1;
            repeat (4) @(negedge clk);
            rdc({CHIP, 2'd0}, `REG_IRQ, 16'h0810);
            rdc({CHIP, 2'd0}, `REG_IRQ, 16'h0810);
            jab[0] = 1'b0;
            repeat (4) @(negedge clk);
            rdc({CHIP, 2'd0}, `REG_IRQ, 16'h0800);
            rdc({CHIP, 2'd3}, `REG_SUMMARY, 16'h0002);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #400000;
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        rst = 1'b1;
        {link, dplx, done, jab} = 16'h0000;
        n_errors = 0;
        check_count = 0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        t_reset_map;
        t_chip_sel;
        t_ctrl;
        t_srst;
        t_irq;
        complete_run;
    end
endmodule // tb_top
